/* pkg/ees_pkg.sv */
// Functional notes
// - Program cycle finishes within 5 ms after stop
// - Write-protect high blocks all array writes
// - SDA changes with SCL high are conditions
// - Falling SDA, SCL high, is start
// - Rising SDA, SCL high, is stop
// - Eight-bit words, acknowledge low on ninth clock
// - Standby at power-up and after finished stop
// - Start, nine clocks, start, stop recovers idle
// - Device word upper nibble must be 1010
// - Bits 3..1 must match the three straps
// - Mismatch gives no acknowledge, wait for start
// - Address LSB one reads, zero writes
// - Byte write: word address, data, stop
// - Ignore bus during the program cycle
// - Page write up to eight bytes, stop
// - Increment low three address bits, wrap page
// - Poll: acknowledge only after program completes
// - Sample on SCL rise, drive after fall
// - Small variant 7-bit address, large 8-bit
package ees_pkg;
	// ==========================================
	// Device address word layout
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	localparam int DEV_TYPE_MSB = 7;
	localparam int DEV_TYPE_LSB = 4;
	localparam int DEV_SEL_MSB = 3;
	localparam int DEV_SEL_LSB = 1;
	localparam int DEV_RW_BIT = 0;
	// ==========================================
	// Word sizes
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	localparam int PAGE_BITS = 3;
	localparam int ADDR_W_LARGE = 8;
	localparam int ADDR_W_SMALL = 7;
	localparam int FIFO_DEPTH = 32;
	// ==========================================
	// Timing
	localparam int unsigned PROG_TIME_MS = 5;
	localparam int unsigned SYS_CLK_KHZ = 100000;
	// Longest time: exact integer product, nothing is rounded
	localparam int unsigned PROG_CYCLES = PROG_TIME_MS * SYS_CLK_KHZ;
	// ==========================================
	// Types
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ees_wr_t;
	localparam int WR_W = $bits(ees_wr_t);
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DEVADR = 5'h02,
		ST_WORDADR = 5'h04,
		ST_DATA = 5'h08,
		ST_IGNORE = 5'h10
	} ees_state_t;
endpackage

/* rtl/ees_fifo.sv */
`timescale 1ns/10ps
module ees_fifo
	import ees_pkg::*;
#(
	parameter int WIDTH = WR_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	// Status
	output logic o_empty
);
	localparam int PW = $clog2(DEPTH);
	// ==========================================
	// Storage and pointers
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;

	// The output register is one of the DEPTH slots, so count it as well
	assign o_in_ready = ((count_reg + (PW+1)'(out_valid_reg)) != (PW+1)'(DEPTH));
	assign push = i_in_valid && o_in_ready;
	// Refill the output register when empty or being taken
	assign pop = (count_reg != '0) && (!out_valid_reg || i_out_ready);
	assign o_out_valid = out_valid_reg;
	assign o_out_data = out_data_reg;
	assign o_empty = !out_valid_reg && (count_reg == '0);

	// Memory write, no reset needed on data
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (i_flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Registered read data
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else if (i_flush) begin
			out_valid_reg <= 1'b0;
		end else if (pop) begin
			out_valid_reg <= 1'b1;
			out_data_reg <= mem_reg[rd_ptr_reg];
		end else if (i_out_ready) begin
			out_valid_reg <= 1'b0;
		end
	end
endmodule

/* rtl/ees_top.sv */
`timescale 1ns/10ps
module ees_top
	import ees_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_LARGE,
	parameter int unsigned P_PROG_CYCLES = PROG_CYCLES,
	parameter int P_FIFO_DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Two-wire bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// Straps and protection
	input wire logic i_chip_select_strap_2,
	input wire logic i_chip_select_strap_1,
	input wire logic i_chip_select_strap_0,
	input wire logic i_write_protect,
	// Array write port
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output ees_wr_t o_wr,
	// Status
	output logic o_busy,
	output logic o_standby
);
	// Counter wide enough for the whole program time
	localparam int CW = $clog2(P_PROG_CYCLES + 1);
	localparam logic [CW-1:0] PROG_LAST = CW'(P_PROG_CYCLES - 1);
	localparam logic [7:0] ADDR_MASK = 8'(2**ADDR_W - 1);
	localparam logic [7:0] PAGE_MASK = 8'(2**PAGE_BITS - 1);

	// ==========================================
	// Reset release
	logic rst_meta_reg;
	logic rst_n;

	// Assert at once, release after two clean edges
	// Keeps a late release from reaching flops on different edges
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ==========================================
	// Pin synchronisers
	// SCL, SDA, protect and the three straps share one bank
	localparam int SYNC_W = 6;
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic scl_prev_reg; // Only reads the second stage
	logic sda_prev_reg;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] strap_s;

	assign pin_raw = {i_scl, i_sda, i_write_protect, i_chip_select_strap_2,
		i_chip_select_strap_1, i_chip_select_strap_0};
	assign scl_s = sync2_reg[5];
	assign sda_s = sync2_reg[4];
	assign wp_s = sync2_reg[3];
	assign strap_s = sync2_reg[2:0];

	// Two flops per pin; bus idles high so SCL and SDA reset to one, the others to zero
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 6'h30;
			sync2_reg <= 6'h30;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// ==========================================
	// Edge and condition detection
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Edges are seen in the same cycle the second stage moves
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	// SDA moving while SCL stays high is never data
	assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	// ==========================================
	// Bus state and byte assembly
	ees_state_t state_reg;
	ees_state_t after_ack_reg; // State to enter once the ack bit ends
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic ack_phase_reg;
	logic [7:0] word_addr_reg;
	logic wr_seen_reg;
	logic read_seen_reg;
	logic busy_reg;
	logic dev_match;
	logic fifo_in_ready;
	logic fifo_push;
	logic byte_done;
	ees_wr_t fifo_in;

	// Upper nibble fixed, then straps, then direction bit
	assign dev_match = (shift_reg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE)
		&& (shift_reg[DEV_SEL_MSB:DEV_SEL_LSB] == strap_s);
	assign byte_done = scl_fall && !ack_phase_reg && (bit_cnt_reg == BIT_CNT_FULL);
	// Protected data is accepted on the wire but never queued
	assign fifo_push = byte_done && (state_reg == ST_DATA) && !wp_s && fifo_in_ready;
	assign fifo_in.addr = word_addr_reg & ADDR_MASK;
	assign fifo_in.data = shift_reg;

	// Shift in on SCL rise; count bits of the current word
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
		end else if (start_det) begin
			// A start always opens a fresh word
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise && !ack_phase_reg && bit_cnt_reg != BIT_CNT_FULL) begin
			// A full count blocks further shifts until the ack ends or a start
			shift_reg <= {shift_reg[BYTE_BITS-2:0], sda_s};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end else if (scl_fall && ack_phase_reg) begin
			// The ninth clock carries no data bit
			bit_cnt_reg <= 4'h0;
		end
	end

	// Main bus sequencer
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			after_ack_reg <= ST_IDLE;
			ack_phase_reg <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (start_det) begin
			// Any start, even mid word, restarts decoding
			state_reg <= ST_DEVADR;
			ack_phase_reg <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (stop_det) begin
			// Stop ends any sequence; programming is decided elsewhere
			state_reg <= ST_IDLE;
			ack_phase_reg <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (scl_fall && ack_phase_reg) begin
			// Ninth clock over: release the line
			o_sda_oe_n <= 1'b1;
			ack_phase_reg <= 1'b0;
			state_reg <= after_ack_reg;
		end else if (byte_done) begin
			unique case (state_reg)
				ST_DEVADR: begin
					// While programming the device stays deaf
					if (dev_match && !busy_reg) begin
						o_sda_oe_n <= 1'b0;
						ack_phase_reg <= 1'b1;
						// Reads are not served; stay silent after the ack
						after_ack_reg <= shift_reg[DEV_RW_BIT] ? ST_IGNORE
							: ST_WORDADR;
					end else begin
						state_reg <= ST_IGNORE;
					end
				end
				ST_WORDADR: begin
					o_sda_oe_n <= 1'b0;
					ack_phase_reg <= 1'b1;
					after_ack_reg <= ST_DATA;
				end
				ST_DATA: begin
					// A full queue refuses the byte rather than lose it
					if (wp_s || fifo_in_ready) begin
						o_sda_oe_n <= 1'b0;
						ack_phase_reg <= 1'b1;
						after_ack_reg <= ST_DATA;
					end else begin
						state_reg <= ST_IGNORE;
					end
				end
				ST_IDLE: begin
					// No start seen yet: bits are not decoded
					state_reg <= ST_IDLE;
				end
				ST_IGNORE: begin
					state_reg <= ST_IGNORE;
				end
			endcase
		end
	end

	// Pin output is only ever a low; the enable does the work
	// Driving a high would fight other devices on the wire
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_sda_out <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
		end
	end

	// ==========================================
	// Word address with page wrap
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_addr_reg <= 8'h00;
		end else if (byte_done && state_reg == ST_WORDADR) begin
			// The address byte loads the pointer outright
			word_addr_reg <= shift_reg & ADDR_MASK;
		end else if (byte_done && state_reg == ST_DATA && (wp_s || fifo_in_ready)) begin
			// Low bits roll within the page, page bits held
			word_addr_reg <= (word_addr_reg & ~PAGE_MASK)
				| ((word_addr_reg + 8'h01) & PAGE_MASK);
		end
	end

	// Track what kind of sequence the next stop ends
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_seen_reg <= 1'b0;
			read_seen_reg <= 1'b0;
		end else if (start_det || stop_det) begin
			wr_seen_reg <= 1'b0;
			read_seen_reg <= 1'b0;
		end else begin
			if (fifo_push) begin
				wr_seen_reg <= 1'b1;
			end
			// A matched read request marks a read sequence
			if (byte_done && state_reg == ST_DEVADR && dev_match && !busy_reg
				&& shift_reg[DEV_RW_BIT]) begin
				read_seen_reg <= 1'b1;
			end
		end
	end

	// ==========================================
	// Write queue
	// Queue holds received bytes until the stop commits them
	logic fifo_out_valid;
	logic fifo_take;
	logic fifo_empty;
	logic [WR_W-1:0] fifo_out;

	// A start that is not a poll drops an unfinished sequence
	ees_fifo #(
		.WIDTH(WR_W),
		.DEPTH(P_FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_sys_clk),
		.i_rst_n(rst_n),
		.i_flush(start_det && !busy_reg),
		.i_in_valid(fifo_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_in),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_take),
		.o_out_data(fifo_out),
		.o_empty(fifo_empty)
	);

	// Array writes only flow during the program cycle
	assign fifo_take = busy_reg && fifo_out_valid && (!o_wr_valid || i_wr_ready);

	// Output stage to the array
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wr_valid <= 1'b0;
			o_wr <= '0;
		end else if (fifo_take) begin
			// A word is held until the array takes it
			o_wr_valid <= 1'b1;
			o_wr <= ees_wr_t'(fifo_out);
		end else if (i_wr_ready) begin
			o_wr_valid <= 1'b0;
		end
	end

	// ==========================================
	// Self-timed program cycle
	logic [CW-1:0] prog_cnt_reg;
	logic prog_timed_reg;

	// Start on a stop after queued data; end when timed out and drained
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			prog_cnt_reg <= '0;
			prog_timed_reg <= 1'b0;
		end else if (!busy_reg) begin
			if (stop_det && wr_seen_reg) begin
				busy_reg <= 1'b1;
				prog_cnt_reg <= '0;
				prog_timed_reg <= 1'b0;
			end
		end else begin
			// Counter stops at the end so a slow drain cannot wrap it
			if (prog_cnt_reg == PROG_LAST) begin
				prog_timed_reg <= 1'b1;
			end else begin
				prog_cnt_reg <= prog_cnt_reg + 1'b1;
			end
			// Drain finishes long before the timer unless the array stalls
			if ((prog_timed_reg || prog_cnt_reg == PROG_LAST) && fifo_empty
				&& !o_wr_valid) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Status outputs
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_busy <= 1'b0;
			o_standby <= 1'b1;
		end else begin
			// Status lags the internal flag by one cycle
			o_busy <= busy_reg;
			// Idle or ignored bus and nothing pending means standby
			o_standby <= (state_reg == ST_IDLE || state_reg == ST_IGNORE)
				&& !busy_reg && !(stop_det && wr_seen_reg);
		end
	end

	// Reads are ignored but still end in standby on stop
	logic unused_read;
	assign unused_read = read_seen_reg;
endmodule

/* tb/ees_bus_ctl.sv */
`timescale 1ns/10ps
// =====
// Bus controller model; 1 means released to the pull-up
module ees_bus_ctl (
	// Clock and wire level
	input wire logic i_clk,
	input wire logic i_sda,
	// Driven pins
	output logic o_scl,
	output logic o_sda
);
	// Bus idles released
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Quarter of the 160 ns bus period
	task automatic q;
		repeat (4) @(posedge i_clk);
	endtask
	// Start, also repeated start from SCL low
	task automatic start;
		o_sda <= 1'b1;
		q;
		o_scl <= 1'b1;
		q;
		o_sda <= 1'b0;
		q;
		o_scl <= 1'b0;
		q;
	endtask
	// One clock; SDA moves only with SCL low
	task automatic bit_clk(input logic b, output logic seen);
		o_sda <= b;
		q;
		o_scl <= 1'b1;
		q;
		seen = i_sda;
		q;
		o_scl <= 1'b0;
		q;
	endtask
	// Byte MSB first; the ninth clock reads the answer
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_clk(b[i], s);
		end
		bit_clk(1'b1, s);
		ack = !s;
	endtask
	// Nine clocks with SDA released, for recovery
	task automatic clk9;
		logic s;
		repeat (9) bit_clk(1'b1, s);
	endtask
	// Stop: SDA rises with SCL high
	task automatic stop;
		o_sda <= 1'b0;
		q;
		o_scl <= 1'b1;
		q;
		o_sda <= 1'b1;
		q;
		q;
	endtask
endmodule

/* tb/ees_top_bench.sv */
`timescale 1ns/10ps
// =====
// Write path bench
module ees_top_bench
	import ees_pkg::*;
	;
	localparam int unsigned PROG = 200; // Short program time keeps the run brief
	localparam logic [7:0] DEV = 8'hAA; // Type 1010, straps 101, write
	// Pins and bookkeeping
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic rdy = 1'b1;
	logic [2:0] strap = 3'h5;
	logic [1:0] stall = 2'h0;
	logic scl, bc_sda, sda_oe_n, sda_out, wr_valid, busy, standby, a;
	wire sda = bc_sda & (sda_oe_n | sda_out);
	ees_wr_t wr;
	ees_wr_t got[$];
	logic [7:0] bad[4] = '{8'hA2, 8'hAE, 8'hA8, 8'hBA};
	int n_fail = 0;
	int n_compared = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	ees_top #(.ADDR_W(ADDR_W_SMALL), .P_PROG_CYCLES(PROG)) i_dut (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_chip_select_strap_2(strap[2]), .i_chip_select_strap_1(strap[1]),
		.i_chip_select_strap_0(strap[0]), .i_write_protect(wp),
		.o_wr_valid(wr_valid), .i_wr_ready(rdy), .o_wr(wr),
		.o_busy(busy), .o_standby(standby)
	);
	ees_bus_ctl i_bc (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(bc_sda));
	// Array sink stalls one cycle in four so holding is exercised
	always @(posedge clk) begin
		stall <= stall + 2'h1;
		rdy <= (stall != 2'h3);
		if (wr_valid && rdy) begin
			got.push_back(wr);
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic exp);
		i_bc.wbyte(b, a);
		check({15'h0, a}, {15'h0, exp});
	endtask
	// Bounded wait for the program flag
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 1000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Run is near 120 us; a hang is cut well beyond
	initial begin
		#500000;
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		check({13'h0, standby, busy, sda_oe_n}, 16'h0005);
		// Nine bytes from offset 6: the last wraps onto the first
		i_bc.start;
		send(DEV, 1'b1);
		send(8'h8E, 1'b1);
		for (int k = 0; k < 9; k++) begin
			send(8'h30 + k[7:0], 1'b1);
		end
		i_bc.stop;
		wait_busy(1'b1);
		check({15'h0, busy}, 16'h0001);
		// Polling while programming gets no answer
		i_bc.start;
		send(DEV, 1'b0);
		send(8'h00, 1'b0);
		i_bc.stop;
		wait_busy(1'b0);
		check({15'h0, busy}, 16'h0000);
		check(16'(got.size()), 16'h0009);
		foreach (got[k]) begin
			check(got[k], {8'h08 | ((8'h06 + k[7:0]) & 8'h07), 8'h30 + k[7:0]});
		end
		i_bc.start;
		send(DEV, 1'b1);
		i_bc.stop;
		// Wrong strap bits and wrong type nibble
		foreach (bad[j]) begin
			i_bc.start;
			send(bad[j], 1'b0);
			send(8'h00, 1'b0);
			check({15'h0, standby}, 16'h0001);
			i_bc.stop;
		end
		// Protected write is answered but never programmed
		wp <= 1'b1;
		i_bc.start;
		send(DEV, 1'b1);
		send(8'h10, 1'b1);
		send(8'h55, 1'b1);
		i_bc.stop;
		wait_busy(1'b1);
		check({15'h0, busy}, 16'h0000);
		check(16'(got.size()), 16'h0009);
		wp <= 1'b0;
		i_bc.start;
		send(DEV | 8'h01, 1'b1);
		i_bc.stop;
		check({15'h0, standby}, 16'h0001);
		// Broken transfer, then the recovery sequence
		i_bc.start;
		send(DEV, 1'b1);
		i_bc.clk9;
		i_bc.start;
		i_bc.stop;
		repeat (8) @(posedge clk);
		check({15'h0, standby}, 16'h0001);
		i_bc.start;
		send(DEV, 1'b1);
		send(8'h05, 1'b1);
		send(8'hA5, 1'b1);
		i_bc.stop;
		wait_busy(1'b1);
		wait_busy(1'b0);
		check(got[$], 16'h05A5);
		// A long page write fills the queue; the byte after it is refused
		i_bc.start;
		send(DEV, 1'b1);
		send(8'h00, 1'b1);
		for (int k = 0; k < 33; k++) begin
			send(8'h40 + k[7:0], k < 32);
		end
		i_bc.stop;
		wait_busy(1'b1);
		wait_busy(1'b0);
		check(16'(got.size()), 16'h002A);
		check(got[10], 16'h0040);
		check(got[$], 16'h075F);
		give_verdict;
	end
endmodule

/* tb/ees_top_properties.sv */
`timescale 1ns/10ps
// =====
// Port checks for the write path
module ees_top_check
	import ees_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_LARGE,
	parameter int unsigned P_PROG_CYCLES = PROG_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Bus pins
	input wire logic i_scl,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	// Array port and status
	input wire logic i_wr_ready,
	input wire logic o_wr_valid,
	input wire ees_wr_t o_wr,
	input wire logic o_busy,
	input wire logic o_standby
);
	// Busy length; slack covers array stalls
	logic [31:0] busy_cnt_reg;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_cnt_reg <= 32'h0;
		end else begin
			busy_cnt_reg <= o_busy ? busy_cnt_reg + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	a_pull_only: assert property (o_sda_out == 1'b0) else $error("sda out high");
	a_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl) else $error("ack edge");
	a_ack_length: assert property ($fell(o_sda_oe_n) |-> (!o_sda_oe_n)[*8] ##[4:12] o_sda_oe_n)
		else $error("ack length");
	a_busy_quiet: assert property (o_busy |-> o_sda_oe_n) else $error("ack while busy");
	a_write_busy: assert property (o_wr_valid |-> o_busy) else $error("write idle");
	a_write_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr))
		else $error("write dropped");
	a_addr_range: assert property (o_wr_valid |-> (o_wr.addr >> ADDR_W) == 8'h0)
		else $error("address range");
	a_standby_busy: assert property (o_busy |-> !o_standby) else $error("standby busy");
	a_busy_bound: assert property (busy_cnt_reg <= P_PROG_CYCLES + 32'h190)
		else $error("program too long");
endmodule
bind ees_top ees_top_check #(.ADDR_W(ADDR_W), .P_PROG_CYCLES(P_PROG_CYCLES)) u_chk (
	.i_sys_clk, .i_reset_n, .i_scl, .o_sda_out, .o_sda_oe_n,
	.i_wr_ready, .o_wr_valid, .o_wr, .o_busy, .o_standby
);
